/* verilog/sbff_spi_top.sv */
// Serial register port with global status byte and latched bus-fault flags
// What this block does
// - Frames are 16, 24 or 32 clocks: address, direction bit, one to three bytes.
// - Burst reads and writes step the register address by one per byte.
// - Input sampled on serial clock rise, output changed on its fall.
// - Output driver enabled only while chip select is low.
// - Chip select fall drives global status bit 7 before any clock.
// - First byte out is always the global status byte.
// - Writes return only the status byte; reads add one to three bytes.
// - Writes commit only at chip select rise after an exact count.
// - A 31-clock burst write commits two bytes and drops the third.
// - A frame with a wrong clock count sets the frame error flag.
// - Enabling fail-safe while asleep keeps the device asleep.
// - Bit 6 latches half termination; flags reset to 0, host write clears.
// - Bit 5 latches the two bus lines shorted together.
// - Bit 4 latches high line to battery; bit 3 low line to ground.
// - Bit 2 latches an open bus wire at any of three places.
// - Bit 1 latches high line or both lines shorted to ground.
// - Bit 0 latches low line or both to battery; bit 7 reads 0.
// - A fault counts only over four long dominant-to-recessive transitions.
`timescale 1ns/1ps
`default_nettype none
module sbff_spi_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link pins
  input wire logic chipSelectN,
  input wire logic serialClockPin,
  input wire logic serialInPin,
  output logic serialOutPin,
  output logic serialOutEnable,
  // Bus fault sensing
  input wire logic busDominant,
  input wire logic [sbff_pkg::NUM_FAULTS-1:0] faultSense,
  // Operating mode control
  input wire logic sleepRequest,
  input wire logic wakeRequest,
  input wire logic failSafeTrigger,
  input wire logic failSafeEnable,
  // Status
  output logic [7:0] busFaultFlags,
  output logic frameErrorFlag,
  output logic globalFault,
  output logic modeSleep,
  output logic modeFailSafe
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic csPrev;
    logic sclkPrev;
    logic [5:0] bitCount;
    logic [7:0] shiftIn;
    logic [6:0] addr;
    logic isWrite;
    logic [2:0][7:0] wdata;
    logic [7:0] outReg;
    logic outBit;
    logic outEn;
    logic [7:0] flags;
    logic frameErr;
    sbff_pkg::sbff_mode_e mode;
  } sbff_top_s;

  sbff_top_s cur;
  sbff_top_s nxt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Pin synchronisation and fault qualification
  // ----------------------------------------------------------------
  sbff_pkg::sbff_link_s linkRaw;
  sbff_pkg::sbff_link_s linkSync;
  logic [sbff_pkg::NUM_FAULTS:0] senseSync;
  logic [sbff_pkg::NUM_FAULTS-1:0] detect;

  // Select travels inverted so a freshly reset synchroniser reads as deselected
  assign linkRaw = '{csN: ~chipSelectN, sclk: serialClockPin, din: serialInPin};

  sbff_sync #(.WIDTH(3)) u_link_sync (
    .clk(clk),
    .rst(rst),
    .asyncIn(linkRaw),
    .syncOut(linkSync)
  );

  sbff_sync #(.WIDTH(sbff_pkg::NUM_FAULTS + 1)) u_sense_sync (
    .clk(clk),
    .rst(rst),
    .asyncIn({busDominant, faultSense}),
    .syncOut(senseSync)
  );

  sbff_fault_qual #(
    .NUM(sbff_pkg::NUM_FAULTS),
    .DOM_MIN(sbff_pkg::DOM_MIN_CYC),
    .NEED(sbff_pkg::FAULT_TRANSITIONS)
  ) u_fault_qual (
    .clk(clk),
    .rst(rst),
    .dominant(senseSync[sbff_pkg::NUM_FAULTS]),
    .faultPresent(senseSync[sbff_pkg::NUM_FAULTS-1:0]),
    .detect(detect)
  );

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Bytes committed for a write frame of the given length
  function automatic logic [1:0] commitBytes(input logic [5:0] count);
    logic [1:0] n;
    n = 2'h0;
    case (count)
      sbff_pkg::FRAME_ONE_BYTE: n = 2'h1;
      sbff_pkg::FRAME_TWO_BYTES: n = 2'h2;
      sbff_pkg::FRAME_SHORT_THREE: n = 2'h2;
      sbff_pkg::FRAME_THREE_BYTES: n = 2'h3;
      default: n = 2'h0;
    endcase
    return n;
  endfunction

  // Write data aimed at one register within a committed burst
  function automatic logic [7:0] clearMask(input logic [6:0] target, input logic [6:0] base,
                                           input logic [1:0] n, input logic [2:0][7:0] data);
    logic [7:0] m;
    m = 8'h00;
    for (int k = 0; k < 3; k++) begin
      if ((2'(k) < n) && (7'(base + 7'(k)) == target)) begin
        m = m | data[k];
      end
    end
    return m;
  endfunction

  function automatic logic [7:0] readByte(input logic [6:0] a, input logic [7:0] glb,
                                          input logic [7:0] flags);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      sbff_pkg::ADDR_GLOBAL: r = glb;
      sbff_pkg::ADDR_BUS_FAULT: r = flags;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Edges and frame bookkeeping
  // ----------------------------------------------------------------
  logic csS;
  logic sclkS;
  logic dinS;
  logic csFall;
  logic csRise;
  logic sclkRise;
  logic sclkFall;
  logic frameValid;
  logic [5:0] newCount;
  logic [1:0] nBytes;
  logic [7:0] glbByte;
  logic [7:0] flagClear;
  logic frameClear;
  logic [7:0] glbClear;
  logic [2:0] byteSlot;

  assign csS = ~linkSync.csN;
  assign sclkS = linkSync.sclk;
  assign dinS = linkSync.din;
  assign csFall = ~csS & cur.csPrev;
  assign csRise = csS & ~cur.csPrev;
  // sample on rise, shift on fall
  assign sclkRise = ~csS & ~csFall & sclkS & ~cur.sclkPrev;
  assign sclkFall = ~csS & ~csFall & ~sclkS & cur.sclkPrev;
  assign newCount = (cur.bitCount == sbff_pkg::COUNT_SATURATE) ? cur.bitCount
                  : cur.bitCount + 6'h01;
  // only these lengths are whole frames
  assign frameValid = (cur.bitCount == sbff_pkg::FRAME_ONE_BYTE)
                    | (cur.bitCount == sbff_pkg::FRAME_TWO_BYTES)
                    | (cur.bitCount == sbff_pkg::FRAME_THREE_BYTES);
  // a 31-clock burst still commits two bytes
  assign nBytes = (csRise && cur.isWrite == sbff_pkg::CMD_WRITE)
                ? commitBytes(cur.bitCount) : 2'h0;
  // unlisted targets get no clear mask
  assign flagClear = clearMask(sbff_pkg::ADDR_BUS_FAULT, cur.addr, nBytes, cur.wdata);
  assign glbClear = clearMask(sbff_pkg::ADDR_GLOBAL, cur.addr, nBytes, cur.wdata);
  assign frameClear = glbClear[sbff_pkg::GLB_FRAME_ERR_BIT];
  assign byteSlot = newCount[5:3] - 3'h2;

  always_comb begin
    glbByte = 8'h00;
    glbByte[sbff_pkg::GLB_FAULT_BIT] = (|cur.flags) | cur.frameErr;
    glbByte[sbff_pkg::GLB_BUS_BIT] = |cur.flags;
    glbByte[sbff_pkg::GLB_FRAME_ERR_BIT] = cur.frameErr;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt = cur;
    nxt.csPrev = csS;
    nxt.sclkPrev = sclkS;

    if (csFall) begin
      // status bit 7 out before any clock
      nxt.bitCount = 6'h00;
      nxt.shiftIn = 8'h00;
      nxt.isWrite = 1'b0;
      // first byte is always global status
      nxt.outReg = glbByte;
      nxt.outBit = glbByte[7];
      nxt.outEn = 1'b1;
    end else if (sclkRise) begin
      nxt.bitCount = newCount;
      nxt.shiftIn = {cur.shiftIn[6:0], dinS};
      if (newCount == sbff_pkg::FRAME_HEADER_BITS) begin
        nxt.addr = cur.shiftIn[6:0];
        nxt.isWrite = dinS;
      end
      if ((newCount[2:0] == 3'h0) && (newCount > sbff_pkg::FRAME_HEADER_BITS)
          && (newCount <= sbff_pkg::FRAME_THREE_BYTES)) begin
        nxt.wdata[byteSlot[1:0]] = {cur.shiftIn[6:0], dinS};
      end
    end else if (sclkFall) begin
      if ((cur.bitCount[2:0] == 3'h0) && (cur.bitCount != 6'h00)) begin
        // writes return zeros after the status byte
        // read data comes from consecutive addresses
        if (cur.isWrite == sbff_pkg::CMD_WRITE) begin
          nxt.outReg = 8'h00;
        end else begin
          nxt.outReg = readByte(7'(cur.addr + 7'(cur.bitCount[5:3] - 3'h1)),
                                glbByte, cur.flags);
        end
        nxt.outBit = nxt.outReg[7];
      end else begin
        nxt.outReg = {cur.outReg[6:0], 1'b0};
        nxt.outBit = cur.outReg[6];
      end
    end

    if (csS) begin
      nxt.outEn = 1'b0;
      nxt.outBit = 1'b0;
    end

    nxt.flags = (cur.flags & ~flagClear) | {1'b0, detect};
    nxt.flags[sbff_pkg::BIT_RESERVED] = 1'b0;

    // wrong length flags an error, set wins
    nxt.frameErr = (cur.frameErr & ~frameClear) | (csRise & ~frameValid);

    // sleep is never left for fail-safe
    case (cur.mode)
      sbff_pkg::MODE_NORMAL: begin
        if (failSafeTrigger && failSafeEnable) begin
          nxt.mode = sbff_pkg::MODE_FAILSAFE;
        end else if (failSafeTrigger || sleepRequest) begin
          nxt.mode = sbff_pkg::MODE_SLEEP;
        end
      end
      sbff_pkg::MODE_SLEEP: begin
        if (wakeRequest) begin
          nxt.mode = sbff_pkg::MODE_NORMAL;
        end
      end
      sbff_pkg::MODE_FAILSAFE: begin
        if (wakeRequest) begin
          nxt.mode = sbff_pkg::MODE_NORMAL;
        end
      end
      default: nxt.mode = sbff_pkg::MODE_NORMAL;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
      cur.csPrev <= 1'b1;
      cur.flags <= sbff_pkg::BUS_FAULT_RESET;
      cur.mode <= sbff_pkg::MODE_NORMAL;
    end else begin
      cur <= nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign serialOutPin = cur.outBit;
  assign serialOutEnable = cur.outEn;
  assign busFaultFlags = cur.flags;
  assign frameErrorFlag = cur.frameErr;
  assign globalFault = (|cur.flags) | cur.frameErr;
  assign modeSleep = (cur.mode == sbff_pkg::MODE_SLEEP);
  assign modeFailSafe = (cur.mode == sbff_pkg::MODE_FAILSAFE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence frameOpen;
    csFall;
  endsequence

  sequence frameClose;
    csRise;
  endsequence

  chk_driver_off_idle: assert property (
    frameClose |=> !serialOutEnable [*2])
    else $error("output driver active while deselected");

  chk_first_status_bit: assert property (
    frameOpen |=> serialOutEnable && (serialOutPin == $past(glbByte[7])))
    else $error("first output bit is not global status bit 7");

  chk_write_zero_data: assert property (
    (sclkFall && cur.isWrite && cur.bitCount >= 6'h08 && !csS) |=> !serialOutPin)
    else $error("write frame returned data after status byte");

  chk_bad_length_error: assert property (
    (frameClose and !frameValid) |=> frameErrorFlag)
    else $error("wrong frame length did not set error");

  chk_clear_at_deselect: assert property (
    ((cur.flags & ~nxt.flags) != 8'h00) |-> csRise)
    else $error("fault flag cleared outside deselect");

  chk_reserved_zero: assert property (
    !busFaultFlags[7])
    else $error("reserved fault bit is set");

  chk_detect_latches: assert property (
    (|detect) |=> ((busFaultFlags[6:0] & $past(detect)) == $past(detect)))
    else $error("detected fault not latched");

  chk_sleep_holds: assert property (
    (modeSleep && !wakeRequest) |=> modeSleep)
    else $error("device left sleep without wake");

  chk_msb_first_shift: assert property (
    sclkRise |=> (cur.shiftIn[0] == $past(dinS)) && (cur.shiftIn[7:1] == $past(cur.shiftIn[6:0])))
    else $error("input bit not shifted in at the bottom");

  chk_short_burst_commit: assert property (
    (frameClose and (cur.isWrite && cur.bitCount == 6'h1f)) |-> nBytes == 2'h2)
    else $error("31-clock write does not commit two bytes");

endmodule
`default_nettype wire

/* verilog/sbff_pkg.sv */
// Shared constants and types of the serial register port and bus-fault flags
package sbff_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int DOM_MIN_NS = 2000;
  // Least time, rounded up to whole cycles
  localparam int DOM_MIN_CYC = (DOM_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FAULT_TRANSITIONS = 4;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam logic [5:0] FRAME_ONE_BYTE = 6'h10;
  localparam logic [5:0] FRAME_TWO_BYTES = 6'h18;
  localparam logic [5:0] FRAME_SHORT_THREE = 6'h1f;
  localparam logic [5:0] FRAME_THREE_BYTES = 6'h20;
  localparam logic [5:0] FRAME_HEADER_BITS = 6'h08;
  localparam logic [5:0] COUNT_SATURATE = 6'h3f;
  localparam logic CMD_WRITE = 1'b1;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_GLOBAL = 7'h50;
  localparam logic [6:0] ADDR_BUS_FAULT = 7'h54;
  localparam logic [7:0] BUS_FAULT_RESET = 8'h00;
  localparam int BIT_RESERVED = 7;
  localparam int BIT_HALF_TERM = 6;
  localparam int BIT_LINES_SHORTED = 5;
  localparam int BIT_HIGH_BATTERY = 4;
  localparam int BIT_LOW_GROUND = 3;
  localparam int BIT_OPEN_WIRE = 2;
  localparam int BIT_GROUND_SHORT = 1;
  localparam int BIT_BATTERY_SHORT = 0;
  localparam int NUM_FAULTS = 7;
  localparam int GLB_FAULT_BIT = 7;
  localparam int GLB_BUS_BIT = 1;
  localparam int GLB_FRAME_ERR_BIT = 0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_FAILSAFE = 2'b10
  } sbff_mode_e;

  typedef struct packed {
    logic csN;
    logic sclk;
    logic din;
  } sbff_link_s;

endpackage

/* verilog/sbff_sync.sv */
// Two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sbff_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sbff_sync_s;

  sbff_sync_s cur;
  sbff_sync_s nxt;

  // First stage feeds only the second
  always_comb begin
    nxt = cur;
    nxt.stage1 = asyncIn;
    nxt.stage2 = cur.stage1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign syncOut = cur.stage2;

endmodule
`default_nettype wire

/* verilog/sbff_fault_qual.sv */
// Bus fault qualifier: a fault counts only across long dominant bits
`timescale 1ns/1ps
`default_nettype none
module sbff_fault_qual #(
  parameter int NUM = sbff_pkg::NUM_FAULTS,
  parameter int DOM_MIN = sbff_pkg::DOM_MIN_CYC,
  parameter int NEED = sbff_pkg::FAULT_TRANSITIONS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Synchronised bus view
  input wire logic dominant,
  input wire logic [NUM-1:0] faultPresent,
  // One-cycle detection pulses
  output logic [NUM-1:0] detect
);

  localparam int DW = $clog2(DOM_MIN + 1);

  typedef struct packed {
    logic prevDom;
    logic [DW-1:0] domCount;
    logic [NUM-1:0][2:0] seen;
    logic [NUM-1:0] det;
  } sbff_qual_s;

  sbff_qual_s cur;
  sbff_qual_s nxt;
  logic longEdge;

  // Dominant-to-recessive edge after a long enough dominant bit
  assign longEdge = cur.prevDom & ~dominant & (cur.domCount >= DW'(DOM_MIN));

  always_comb begin
    nxt = cur;
    nxt.prevDom = dominant;
    nxt.det = '0;
    if (!dominant) begin
      nxt.domCount = '0;
    end else if (cur.domCount < DW'(DOM_MIN)) begin
      nxt.domCount = cur.domCount + DW'(1);
    end
    for (int k = 0; k < NUM; k++) begin
      if (!faultPresent[k]) begin
        nxt.seen[k] = 3'h0;
      end else if (longEdge) begin
        if (cur.seen[k] == 3'(NEED - 1)) begin
          nxt.seen[k] = 3'h0;
          nxt.det[k] = 1'b1;
        end else begin
          nxt.seen[k] = cur.seen[k] + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign detect = cur.det;

  // detection needs the last of the transitions
  chk_qual_needs_edge: assert property (@(posedge clk) disable iff (rst)
    |cur.det |-> $past(longEdge))
    else $error("fault detected without a long dominant edge");

endmodule
`default_nettype wire

/* verification/sbff_host_model.sv */
// Host model: serial master that drives frames of up to 32 clocks onto the register port
`timescale 1ns/1ps
`default_nettype none
module sbff_host_model (
  // Link pins toward the device
  output logic csN,
  output logic sclk,
  output logic mosi,
  // Return line as seen on the wire
  input wire logic miso,
  input wire logic misoEn
);
  // ----------------------------------------
  // Frame engine
  // ----------------------------------------
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  task automatic xfer(input int nbits, input logic [31:0] tx, output logic [31:0] rx,
      output logic enAll);
    rx = 32'h00000000;
    enAll = 1'b1;
    csN = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi = tx[31 - i];
      #62.5;
      // data changes on fall, sampled on rise
      sclk = 1'b1;
      rx = {rx[30:0], miso};
      enAll = enAll & misoEn;
      #62.5;
      sclk = 1'b0;
    end
    #62.5;
    csN = 1'b1;
    // Released data line must not keep the last bit
    mosi = ~mosi;
    #2100;
  endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the serial register port and bus-fault flags
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wire logic csN;
  wire logic sclk;
  wire logic mosi;
  wire logic sdoWire;
  logic serialOutPin;
  logic serialOutEnable;
  logic busDominant = 1'b0;
  logic [6:0] faultSense = 7'h00;
  logic sleepRequest = 1'b0;
  logic wakeRequest = 1'b0;
  logic failSafeTrigger = 1'b0;
  logic failSafeEnable = 1'b0;
  logic [7:0] busFaultFlags;
  logic frameErrorFlag;
  logic globalFault;
  logic modeSleep;
  logic modeFailSafe;
  logic sdoLast = 1'b0;
  int fails = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'h0000001c;
  logic [7:0] mFlags = 8'h00;
  logic mErr = 1'b0;

  always #5 clk = ~clk;

  // Undriven line shows the inverse of the last bit, not a stale copy
  always @(posedge clk) if (serialOutEnable) sdoLast <= serialOutPin;
  assign sdoWire = serialOutEnable ? serialOutPin : ~sdoLast;

  sbff_spi_top u_sbff_spi_top (.clk(clk), .rst(rst), .chipSelectN(csN),
    .serialClockPin(sclk), .serialInPin(mosi), .serialOutPin(serialOutPin),
    .serialOutEnable(serialOutEnable), .busDominant(busDominant), .faultSense(faultSense),
    .sleepRequest(sleepRequest), .wakeRequest(wakeRequest), .failSafeTrigger(failSafeTrigger),
    .failSafeEnable(failSafeEnable), .busFaultFlags(busFaultFlags),
    .frameErrorFlag(frameErrorFlag), .globalFault(globalFault), .modeSleep(modeSleep),
    .modeFailSafe(modeFailSafe));

  sbff_host_model u_sbff_host_model (.csN(csN), .sclk(sclk), .mosi(mosi), .miso(sdoWire),
    .misoEn(serialOutEnable));

  // ----------------------------------------
  // Model and helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] glb();
    return {(|mFlags) | mErr, 5'h00, |mFlags, mErr};
  endfunction

  function automatic logic [7:0] regByte(input logic [6:0] a);
    if (a == sbff_pkg::ADDR_BUS_FAULT) return mFlags;
    if (a == sbff_pkg::ADDR_GLOBAL) return glb();
    return 8'h00;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One frame: reply checked against the model, model updated at deselect
  task automatic frame(input int n, input logic [6:0] a, input logic wr, input logic [23:0] d);
    logic [31:0] rx;
    logic [31:0] exp;
    logic en;
    int nb;
    exp = {glb(), 24'h000000};
    if (!wr) exp[23:0] = {regByte(a), regByte(a + 7'h01), regByte(a + 7'h02)};
    @(negedge clk);
    u_sbff_host_model.xfer(n, {a, wr, d}, rx, en);
    check(rx, exp >> (32 - n), "serial reply");
    check(en, 1'b1, "driver on in frame");
    // Short three-byte write still commits two bytes
    nb = (n == 31) ? 2 : ((n == 16 || n == 24 || n == 32) ? (n - 8) / 8 : 0);
    for (int k = 0; k < nb; k++) begin
      if (wr && a + 7'(k) == sbff_pkg::ADDR_BUS_FAULT) mFlags = mFlags & ~d[23 - 8 * k -: 8];
      if (wr && a + 7'(k) == sbff_pkg::ADDR_GLOBAL && d[16 - 8 * k]) mErr = 1'b0;
    end
    if (n != 16 && n != 24 && n != 32) mErr = 1'b1;
    @(negedge clk);
    check(busFaultFlags, mFlags, "flags after frame");
    check(frameErrorFlag, mErr, "frame error");
    check(globalFault, (|mFlags) | mErr, "global fault");
    check({serialOutEnable, serialOutPin}, 2'b00, "released pin");
  endtask

  // Fault held over five dominant bits of the given length
  task automatic raise(input logic [6:0] s, input int dom);
    @(negedge clk);
    faultSense = s;
    repeat (5) begin
      busDominant = 1'b1;
      repeat (dom) @(negedge clk);
      busDominant = 1'b0;
      repeat (30) @(negedge clk);
    end
    faultSense = 7'h00;
    repeat (10) @(negedge clk);
    if (dom >= sbff_pkg::DOM_MIN_CYC) mFlags = mFlags | {1'b0, s};
    check(busFaultFlags, mFlags, "latched flags");
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    check(busFaultFlags, 8'h00, "flag reset");
    frame(16, 7'h54, 1'b0, 24'h000000);
    $display("Test reset done");
    for (int b = 0; b < 7; b++) begin
      raise(7'(7'h01 << b), 210);
      frame(16, 7'h54, 1'b0, 24'h000000);
      frame(16, 7'h54, 1'b1, {8'(8'h01 << b), 16'h0000});
    end
    $display("Test single flags done");
    raise(7'h7f, 150);
    r = rnd();
    raise(r[6:0], 210);
    raise(7'h7f, 210);
    frame(32, 7'h52, 1'b0, 24'h000000);
    frame(24, 7'h4f, 1'b0, 24'h000000);
    r = rnd();
    frame(16, 7'h54, 1'b1, {r[7:0], 16'h0000});
    frame(24, 7'h53, 1'b1, {8'hff, 8'h30, 8'h00});
    $display("Test bursts done");
    raise(7'h7f, 210);
    frame(31, 7'h53, 1'b1, {8'hff, 8'h0f, 8'hff});
    frame(31, 7'h52, 1'b1, {8'h00, 8'h00, 8'h70});
    frame(16, 7'h50, 1'b1, {8'h01, 16'h0000});
    frame(20, 7'h54, 1'b0, 24'h000000);
    frame(16, 7'h50, 1'b1, {8'h01, 16'h0000});
    frame(12, 7'h54, 1'b1, 24'hffffff);
    frame(24, 7'h50, 1'b1, {8'h01, 8'h7f, 8'h00});
    $display("Test framing errors done");
    pulse(failSafeTrigger);
    check({modeSleep, modeFailSafe}, 2'b10, "fault without fail-safe sleeps");
    pulse(wakeRequest);
    pulse(sleepRequest);
    failSafeEnable = 1'b1;
    pulse(failSafeTrigger);
    check({modeSleep, modeFailSafe}, 2'b10, "stay asleep");
    pulse(wakeRequest);
    check({modeSleep, modeFailSafe}, 2'b00, "woken");
    pulse(failSafeTrigger);
    check({modeSleep, modeFailSafe}, 2'b01, "fail-safe from normal");
    pulse(wakeRequest);
    $display("Test modes done");
    end_sim();
  end

  initial begin
    #800000;
    fails++;
    $display("CHECK FAILED at %0t: run limit reached", $time);
    end_sim();
  end
endmodule
`default_nettype wire
